// ==== hw/modem_pkg.sv ====
package modem_pkg;
	// avalon byte addresses, one 32-bit word each
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFF_LINE_CONTROL = 4'h0;
	localparam logic [3:0] OFF_LINE_STATUS = 4'h4;
	localparam logic [3:0] OFF_INT_ENABLE = 4'h8;
	// modem_line_control fields
	localparam int CTL_W = 5;
	localparam int CTL_DTR = 0;
	localparam int CTL_RTS = 1;
	localparam int CTL_AUX_ONE = 2;
	localparam int CTL_AUX_TWO = 3;
	localparam int CTL_LOOP = 4;
	localparam logic [4:0] CTL_RESET = 5'h00;
	// modem_line_status: deltas in 3:0, levels in 7:4
	localparam int STS_W = 8;
	localparam int NUM_IN = 4;
	localparam int IN_CTS = 0;
	localparam int IN_DSR = 1;
	localparam int IN_RING = 2;
	localparam int IN_DCD = 3;
	localparam int STS_LEVEL_LSB = 4;
	// interrupt_enable_reg
	localparam int IER_W = 8;
	localparam int IER_MODEM = 3;
	localparam logic [7:0] IER_RESET = 8'h00;
	localparam logic [3:0] IN_RESET = 4'h0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

// ==== hw/modem_delta_flag.sv ====
`timescale 1ns/1ps
`default_nettype none
module modem_delta_flag (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic change,
	input wire logic read_busy,
	input wire logic read_done,
	output logic flag
);
	logic flag_q;
	logic pend_q;

	// change seen while the status read is in progress
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pend_q <= 1'b0;
		end else if (read_done) begin
			pend_q <= 1'b0;
		end else if (read_busy && change) begin
			pend_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= 1'b0;
		end else if (read_done) begin
			// read clears a set flag; a pending change sets the flag only if it was clear
			flag_q <= (change | pend_q) & ~flag_q;
		end else if (!read_busy && change) begin
			flag_q <= 1'b1;
		end
	end

	assign flag = flag_q;
endmodule
`default_nettype wire

// ==== hw/modem_ctrl_status.sv ====
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module modem_ctrl_status (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic dtr_n,
	output logic rts_n,
	output logic aux_output_one_n,
	output logic aux_output_two_n,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ring_n,
	input wire logic line_signal_detect_n,
	output logic serial_tx_pin,
	input wire logic serial_rx_pin,
	input wire logic tx_shift_out,
	output logic rx_shift_in,
	output logic modem_status_irq
);
	logic [modem_pkg::CTL_W-1:0] ctrl_q;
	logic [modem_pkg::IER_W-1:0] ier_q;
	logic [modem_pkg::NUM_IN-1:0] level_q;
	logic [modem_pkg::NUM_IN-1:0] level_d;
	logic [modem_pkg::NUM_IN-1:0] change;
	logic [modem_pkg::NUM_IN-1:0] delta;
	logic [31:0] readdata_q;
	logic [31:0] rd_mux;
	logic ack_q;
	logic init_q;
	logic loop;
	logic sel_ctl;
	logic sel_sts;
	logic sel_ier;
	logic wr_done;
	logic rd_first;
	logic sts_busy;
	logic sts_done;
	logic dtr_n_q;
	logic rts_n_q;
	logic aux_one_n_q;
	logic aux_two_n_q;
	logic tx_pin_q;
	logic rx_in_q;
	logic irq_q;

	// bus handshake: one wait cycle, request completes on the next edge
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_done = avs_write & ack_q;
	assign rd_first = avs_read & ~ack_q;

	always_comb begin
		sel_ctl = 1'b0;
		sel_sts = 1'b0;
		sel_ier = 1'b0;
		if (avs_address == modem_pkg::OFF_LINE_CONTROL) begin
			sel_ctl = 1'b1;
		end else if (avs_address == modem_pkg::OFF_LINE_STATUS) begin
			sel_sts = 1'b1;
		end else if (avs_address == modem_pkg::OFF_INT_ENABLE) begin
			sel_ier = 1'b1;
		end
	end

	assign sts_busy = avs_read & sel_sts;
	assign sts_done = sts_busy & ack_q;
	assign loop = ctrl_q[modem_pkg::CTL_LOOP];

	// control register, low byte lane only
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= modem_pkg::CTL_RESET;
		end else if (wr_done && sel_ctl && avs_byteenable[0]) begin
			ctrl_q <= avs_writedata[modem_pkg::CTL_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ier_q <= modem_pkg::IER_RESET;
		end else if (wr_done && sel_ier && avs_byteenable[0]) begin
			ier_q <= avs_writedata[modem_pkg::IER_W-1:0];
		end
	end

	// read data captured on the first edge, stands at completion
	always_comb begin
		rd_mux = modem_pkg::RDATA_RESET;
		if (sel_ctl) begin
			rd_mux[modem_pkg::CTL_W-1:0] = ctrl_q;
		end else if (sel_sts) begin
			rd_mux[modem_pkg::STS_W-1:0] = {level_q, delta};
		end else if (sel_ier) begin
			rd_mux[modem_pkg::IER_W-1:0] = ier_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			readdata_q <= modem_pkg::RDATA_RESET;
		end else if (rd_first) begin
			readdata_q <= rd_mux;
		end
	end

	assign avs_readdata = readdata_q;

	// pins: inactive high in loopback, else inverted control bits
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			dtr_n_q <= 1'b1;
			rts_n_q <= 1'b1;
			aux_one_n_q <= 1'b1;
			aux_two_n_q <= 1'b1;
		end else begin
			dtr_n_q <= loop | ~ctrl_q[modem_pkg::CTL_DTR];
			rts_n_q <= loop | ~ctrl_q[modem_pkg::CTL_RTS];
			aux_one_n_q <= loop | ~ctrl_q[modem_pkg::CTL_AUX_ONE];
			aux_two_n_q <= loop | ~ctrl_q[modem_pkg::CTL_AUX_TWO];
		end
	end

	// serial path: in loopback, mark the line and wrap transmit into receive
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tx_pin_q <= 1'b1;
			rx_in_q <= 1'b1;
		end else begin
			tx_pin_q <= loop | tx_shift_out;
			rx_in_q <= loop ? tx_shift_out : serial_rx_pin;
		end
	end

	assign dtr_n = dtr_n_q;
	assign rts_n = rts_n_q;
	assign aux_output_one_n = aux_one_n_q;
	assign aux_output_two_n = aux_two_n_q;
	assign serial_tx_pin = tx_pin_q;
	assign rx_shift_in = rx_in_q;

	// modem input levels, 1 = pin low
	always_comb begin
		if (loop) begin
			level_d[modem_pkg::IN_CTS] = ctrl_q[modem_pkg::CTL_RTS];
			level_d[modem_pkg::IN_DSR] = ctrl_q[modem_pkg::CTL_DTR];
			level_d[modem_pkg::IN_RING] = ctrl_q[modem_pkg::CTL_AUX_ONE];
			level_d[modem_pkg::IN_DCD] = ctrl_q[modem_pkg::CTL_AUX_TWO];
		end else begin
			level_d[modem_pkg::IN_CTS] = ~cts_n;
			level_d[modem_pkg::IN_DSR] = ~dsr_n;
			level_d[modem_pkg::IN_RING] = ~ring_n;
			level_d[modem_pkg::IN_DCD] = ~line_signal_detect_n;
		end
	end

	// first sample after reset only primes the edge detector
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			level_q <= modem_pkg::IN_RESET;
			init_q <= 1'b0;
		end else begin
			level_q <= level_d;
			init_q <= 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < modem_pkg::NUM_IN; gi++) begin : g_delta
			if (gi == modem_pkg::IN_RING) begin : g_ring
				// status 1 -> 0 means the ring pin went back high
				assign change[gi] = init_q & level_q[gi] & ~level_d[gi];
			end else begin : g_any
				assign change[gi] = init_q & (level_q[gi] ^ level_d[gi]);
			end
			modem_delta_flag u_flag (
				.clk_sys(clk_sys),
				.rst_b(rst_b),
				.change(change[gi]),
				.read_busy(sts_busy),
				.read_done(sts_done),
				.flag(delta[gi])
			);
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= ier_q[modem_pkg::IER_MODEM] & (|delta);
		end
	end

	assign modem_status_irq = irq_q;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence ctl_write_s;
		wr_done && sel_ctl && avs_byteenable[0];
	endsequence

	sequence loop_held_s;
		loop [*2];
	endsequence

	sequence quiet_s;
		!loop && !sts_busy && !$past(loop);
	endsequence

	ctrl_readback_a: assert property (
		ctl_write_s |=> ctrl_q == $past(avs_writedata[4:0]))
		else $error("control register did not take write");

	dtr_pin_a: assert property (
		!loop ##1 !loop |-> dtr_n == !$past(ctrl_q[0]))
		else $error("dtr_n does not follow its bit");

	rts_pin_a: assert property (
		!loop ##1 !loop |-> rts_n == !$past(ctrl_q[1]))
		else $error("rts_n does not follow its bit");

	aux_one_pin_a: assert property (
		!loop |=> aux_output_one_n == !$past(ctrl_q[2]))
		else $error("aux one pin does not follow its bit");

	aux_two_pin_a: assert property (
		!loop |=> aux_output_two_n == !$past(ctrl_q[3]))
		else $error("aux two pin does not follow its bit");

	tx_mark_a: assert property (
		loop |=> serial_tx_pin && rx_shift_in == $past(tx_shift_out))
		else $error("loopback serial path wrong");

	rx_wrap_a: assert property (
		loop ##1 loop |-> rx_shift_in == $past(tx_shift_out))
		else $error("transmit not wrapped to receive");

	loop_levels_a: assert property (
		loop_held_s |-> level_q == {$past(ctrl_q[3]), $past(ctrl_q[2]),
			$past(ctrl_q[0]), $past(ctrl_q[1])})
		else $error("loopback levels do not mirror control");

	pins_parked_a: assert property (
		loop |=> dtr_n && rts_n && aux_output_one_n && aux_output_two_n)
		else $error("modem pins not parked in loopback");

	delta_set_a: assert property (
		quiet_s and (init_q && level_d[0] != level_q[0]) |=> delta[0])
		else $error("cts change did not set its delta");

	delta_clear_a: assert property (
		sts_done && !change[1] && !$past(sts_busy && change[1])
		|=> !delta[1])
		else $error("status read did not clear delta");

	level_pins_a: assert property (
		!loop |=> level_q == ~{$past(line_signal_detect_n), $past(ring_n),
			$past(dsr_n), $past(cts_n)})
		else $error("status levels not inverted pins");

	irq_link_a: assert property (
		ier_q[3] && (|delta) ##1 ier_q[3] |-> modem_status_irq)
		else $error("enabled delta gave no interrupt");

	ring_fall_a: assert property (
		!sts_busy && !delta[2] && !level_q[2] |=> !delta[2])
		else $error("ring delta set on leading edge");

	read_no_set_a: assert property (
		sts_busy && !ack_q |=> (delta & ~$past(delta)) == 4'h0)
		else $error("delta set during status read");
endmodule
`default_nettype wire

// ==== verif/modem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module modem_model #(
	parameter int LAG = 2
) (
	input wire logic clk_sys,
	input wire logic dtr_n,
	input wire logic rts_n,
	output logic cts_n,
	output logic dsr_n,
	output logic ring_n,
	output logic line_signal_detect_n,
	output logic serial_rx_pin
);
	// line order {dcd, ring, dsr, cts}, idle high
	logic [3:0] lines_q = 4'hf;
	logic sin_q = 1'b1;
	assign {line_signal_detect_n, ring_n, dsr_n, cts_n} = lines_q;
	assign serial_rx_pin = sin_q;
	// data set answers LAG cycles after being asked
	task automatic drive(input logic [3:0] l, input logic s);
		repeat (LAG) @(posedge clk_sys);
		lines_q <= l;
		sin_q <= s;
	endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [3:0] ctl_a = modem_pkg::OFF_LINE_CONTROL;
	localparam logic [3:0] sts_a = modem_pkg::OFF_LINE_STATUS;
	localparam logic [3:0] ier_a = modem_pkg::OFF_INT_ENABLE;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'h0;
	logic tx_shift_out = 1'b0;
	logic [31:0] avs_readdata, q;
	logic avs_waitrequest, dtr_n, rts_n, aux_output_one_n, aux_output_two_n;
	logic cts_n, dsr_n, ring_n, line_signal_detect_n, modem_status_irq;
	logic serial_tx_pin, serial_rx_pin, rx_shift_in;
	int errors = 0;
	int tests_run = 0;
	always #2.5 clk_sys = ~clk_sys;
	modem_ctrl_status u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .dtr_n(dtr_n), .rts_n(rts_n),
		.aux_output_one_n(aux_output_one_n),
		.aux_output_two_n(aux_output_two_n), .cts_n(cts_n), .dsr_n(dsr_n),
		.ring_n(ring_n), .line_signal_detect_n(line_signal_detect_n),
		.serial_tx_pin(serial_tx_pin), .serial_rx_pin(serial_rx_pin),
		.tx_shift_out(tx_shift_out), .rx_shift_in(rx_shift_in),
		.modem_status_irq(modem_status_irq));
	modem_model #(.LAG(2)) u_modem (.clk_sys(clk_sys), .dtr_n(dtr_n),
		.rts_n(rts_n), .cts_n(cts_n), .dsr_n(dsr_n), .ring_n(ring_n),
		.line_signal_detect_n(line_signal_detect_n),
		.serial_rx_pin(serial_rx_pin));
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			errors++;
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		// waitrequest and readdata read as they stand at the edge
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk_sys);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h00_0000, d}, 4'hf);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, string s);
		bus(1'b0, a, 32'h0000_0000, 4'hf);
		check(s, {24'h00_0000, e}, q);
	endtask
	task automatic look;
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic lines(input logic [3:0] l, input logic s);
		u_modem.drive(l, s);
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic pins(input logic [3:0] e);
		check("pins", {28'h000_0000, e}, {28'h000_0000, aux_output_two_n,
			aux_output_one_n, rts_n, dtr_n});
	endtask
	task automatic t_control;
		logic [7:0] v[7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'hef, 8'h00};
		rd(ctl_a, 8'h00, "ctl reset");
		pins(4'hf);
		foreach (v[i]) begin
			wr(ctl_a, v[i]);
			rd(ctl_a, v[i] & 8'h1f, "ctl back");
			look();
			pins(~v[i][3:0]);
		end
		bus(1'b1, ctl_a, 32'h0000_0003, 4'he);
		rd(ctl_a, 8'h00, "no lane0");
		rd(4'hc, 8'h00, "unmapped");
		$display("control test done");
	endtask
	task automatic t_status;
		rd(sts_a, 8'h00, "sts idle");
		lines(4'he, 1'b1);
		check("irq off", 32'h0, {31'h0, modem_status_irq});
		wr(ier_a, 8'h08);
		look();
		check("irq on", 32'h1, {31'h0, modem_status_irq});
		rd(sts_a, 8'h11, "cts");
		look();
		check("irq clr", 32'h0, {31'h0, modem_status_irq});
		rd(sts_a, 8'h10, "cleared");
		lines(4'ha, 1'b1);
		rd(sts_a, 8'h50, "ring lead");
		lines(4'he, 1'b1);
		rd(sts_a, 8'h14, "ring trail");
		lines(4'h4, 1'b1);
		rd(sts_a, 8'hba, "dsr dcd");
		lines(4'hf, 1'b1);
		rd(sts_a, 8'h0b, "all idle");
		wr(ier_a, 8'h00);
		$display("status test done");
	endtask
	task automatic t_loop;
		wr(ctl_a, 8'h1f);
		look();
		pins(4'hf);
		check("mark", 32'h1, {31'h0, serial_tx_pin});
		lines(4'h0, 1'b0);
		tx_shift_out <= 1'b1;
		look();
		check("loop rx", 32'h1, {31'h0, rx_shift_in});
		@(posedge clk_sys);
		tx_shift_out <= 1'b0;
		look();
		check("loop rx0", 32'h0, {31'h0, rx_shift_in});
		rd(sts_a, 8'hfb, "loop sts");
		wr(ctl_a, 8'h11);
		rd(sts_a, 8'h2d, "loop dtr");
		lines(4'hf, 1'b0);
		wr(ctl_a, 8'h00);
		rd(sts_a, 8'h02, "loop off");
		look();
		check("tx path", 32'h0, {31'h0, serial_tx_pin});
		check("rx path", 32'h0, {31'h0, rx_shift_in});
		$display("loopback test done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_control();
		t_status();
		t_loop();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
